// >>> src/tmz_pkg.sv
// Purpose: constants and carriers for the eight-bit up-counting timer
// Assumes: registers reached over APB, one 32-bit aligned word each
// Notes: all offsets below are byte addresses
// Behaviour
// - count up on each qualified event, only while the run enable bit is set
// - a written count loads at once; a read returns the live count
// - source select 0 counts the instruction clock, slow select ignored
// - source select 1, slow select 0 counts the external count pin
// - both selects and source setting 1 count the chosen slow oscillator
// - edge select 1 counts falling edges, 0 counts rising edges
// - assignment bit 0 puts the prescaler between source and counter
// - writing 0 to the assignment bit clears the prescaler afterwards
// - three-bit ratio field divides from 1:2 up to 1:256
// - by default the source is synchronised to the instruction clock
// - asynchronous option bypasses the instruction-clock alignment stage
// - counter overflow sets the overflow flag
// - flag with both interrupt enables set raises the interrupt request
// - overflow flag stays set until software writes 0 to it
// - assignment bit 1 hands the prescaler away; counter counts undivided
package tmz_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PCTRL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FLAG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_INTEN = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PRESC = 8'h18;
  // timer mode register fields
  localparam int MODE_SLOW = 7;
  localparam int MODE_SRC = 5;
  localparam int MODE_EDGE = 4;
  localparam int MODE_PSA = 3;
  localparam int MODE_RATIO_LSB = 0;
  localparam int RATIO_W = 3;
  // power control 1 fields
  localparam int PCTRL_RUN = 0;
  localparam int PCTRL_GIE = 7;
  localparam int FLAG_OVF = 0;
  localparam int INTEN_OVF = 0;
  // configuration option fields
  localparam int CFG_ASYNC = 0;
  localparam int CFG_XTAL = 1;
  localparam int CFG_T0SRC = 2;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PCTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] PSC_RST = 8'h00;
  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT = 3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } tmz_apb_req_s;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } tmz_apb_rsp_s;
endpackage

// >>> src/tmz_timer0.sv
// Purpose: eight-bit up-counting timer with shared prescaler, APB slave
// Assumes: clock is the instruction clock; source pins are asynchronous
// Notes: every APB access answers with pready in the second access cycle
`timescale 1ns/100ps
module tmz_timer0 (
  input logic clock, // instruction clock, 100 MHz
  input logic reset_n, // synchronous reset, active low
  input tmz_pkg::tmz_apb_req_s apbReq, // APB request group
  output tmz_pkg::tmz_apb_rsp_s apbRsp, // APB answer group
  input logic extCountIn, // external count input pin
  input logic intSlowRc, // internal slow RC oscillator
  input logic extSlowXtal, // external slow crystal oscillator
  output logic irqOut // overflow interrupt request
);
  import tmz_pkg::*;

  logic [7:0] count_reg;
  logic [7:0] mode_reg;
  logic [7:0] pctrl_reg;
  logic [7:0] cfg_reg;
  logic [7:0] psc_reg;
  logic flag_reg;
  logic inten_reg;
  logic irq_reg;
  logic [PIN_COUNT-1:0] syncA_reg;
  logic [PIN_COUNT-1:0] syncB_reg;
  logic align_reg;
  logic alignPrev_reg;
  tmz_apb_rsp_s rsp_reg;
  logic [8:0] evtSince_reg;

  logic access;
  logic wrEn;
  logic wrCount;
  logic wrMode;
  logic wrFlag;
  logic [7:0] wdata;
  logic [DATA_W-1:0] rdData;
  logic addrHit;
  logic run;
  logic srcSel;
  logic slowSel;
  logic psa;
  logic async;
  logic selLevel;
  logic curLevel;
  logic prevLevel;
  logic edgeSeen;
  logic srcEvent;
  logic [7:0] pscMask;
  logic pscHit;
  logic countEvent;
  logic overflow;

  // ---------------- APB slave ----------------
  assign access = apbReq.psel & apbReq.penable;
  // writes land only on the edge where pready is sampled high
  assign wrEn = access & apbReq.pwrite & rsp_reg.pready;
  assign wdata = apbReq.pwdata[7:0];
  assign wrCount = wrEn & (apbReq.paddr == OFF_COUNT);
  assign wrMode = wrEn & (apbReq.paddr == OFF_MODE);
  assign wrFlag = wrEn & (apbReq.paddr == OFF_FLAG);

  always_comb begin
    rdData = '0;
    addrHit = 1'b1;
    if (apbReq.paddr == OFF_COUNT) begin
      rdData[7:0] = count_reg;
    end else if (apbReq.paddr == OFF_MODE) begin
      rdData[7:0] = mode_reg;
    end else if (apbReq.paddr == OFF_PCTRL) begin
      rdData[7:0] = pctrl_reg;
    end else if (apbReq.paddr == OFF_FLAG) begin
      rdData[FLAG_OVF] = flag_reg;
    end else if (apbReq.paddr == OFF_INTEN) begin
      rdData[INTEN_OVF] = inten_reg;
    end else if (apbReq.paddr == OFF_CFG) begin
      rdData[7:0] = cfg_reg;
    end else if (apbReq.paddr == OFF_PRESC) begin
      rdData[7:0] = psc_reg;
    end else begin
      addrHit = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rsp_reg <= '0;
    end else if (access && !rsp_reg.pready) begin
      rsp_reg.pready <= 1'b1;
      rsp_reg.prdata <= apbReq.pwrite ? '0 : rdData;
      rsp_reg.pslverr <= !addrHit;
    end else begin
      rsp_reg <= '0;
    end
  end

  assign apbRsp = rsp_reg;

  // ---------------- control registers ----------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mode_reg <= MODE_RST;
    end else if (wrMode) begin
      mode_reg <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      pctrl_reg <= PCTRL_RST;
    end else if (wrEn && apbReq.paddr == OFF_PCTRL) begin
      pctrl_reg <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cfg_reg <= CFG_RST;
    end else if (wrEn && apbReq.paddr == OFF_CFG) begin
      cfg_reg <= wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      inten_reg <= 1'b0;
    end else if (wrEn && apbReq.paddr == OFF_INTEN) begin
      inten_reg <= wdata[INTEN_OVF];
    end
  end

  assign run = pctrl_reg[PCTRL_RUN];
  assign srcSel = mode_reg[MODE_SRC];
  assign slowSel = mode_reg[MODE_SLOW];
  assign psa = mode_reg[MODE_PSA];
  assign async = cfg_reg[CFG_ASYNC];

  // ---------------- source selection and edge qualify ----------------
  // pins: 0 count pin, 1 slow RC, 2 slow crystal
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      syncA_reg <= '0;
      syncB_reg <= '0;
    end else begin
      syncA_reg <= {extSlowXtal, intSlowRc, extCountIn};
      syncB_reg <= syncA_reg;
    end
  end

  always_comb begin
    if (slowSel && cfg_reg[CFG_T0SRC]) begin
      selLevel = cfg_reg[CFG_XTAL] ? syncB_reg[2] : syncB_reg[1];
    end else begin
      selLevel = syncB_reg[0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      align_reg <= 1'b0;
      alignPrev_reg <= 1'b0;
    end else begin
      align_reg <= selLevel;
      alignPrev_reg <= align_reg;
    end
  end

  // the alignment stage costs one cycle; the async option skips it
  assign curLevel = async ? selLevel : align_reg;
  assign prevLevel = async ? align_reg : alignPrev_reg;
  // edge select 1 means falling edges count
  assign edgeSeen = mode_reg[MODE_EDGE] ? (prevLevel & ~curLevel)
                                        : (~prevLevel & curLevel);
  // instruction clock: every cycle is a source event
  assign srcEvent = srcSel ? edgeSeen : 1'b1;

  // ---------------- prescaler ----------------
  // ratio r divides by 2^(r+1): mask of r+1 low ones
  assign pscMask = 8'((9'h002 << mode_reg[MODE_RATIO_LSB +: RATIO_W])
                      - 9'h001);
  assign pscHit = (psc_reg & pscMask) == pscMask;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      psc_reg <= PSC_RST;
    end else if (wrMode && !wdata[MODE_PSA]) begin
      psc_reg <= PSC_RST;
    end else if (run && srcEvent && !psa) begin
      psc_reg <= psc_reg + 8'h01;
    end
  end

  // with the prescaler handed away the counter sees every source event
  assign countEvent = run & srcEvent & (psa | pscHit);

  // ---------------- counter and overflow ----------------
  assign overflow = countEvent & !wrCount & (count_reg == 8'hff);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_reg <= COUNT_RST;
    end else if (wrCount) begin
      count_reg <= wdata;
    end else if (countEvent) begin
      count_reg <= count_reg + 8'h01;
    end
  end

  // set beats a clear landing in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else if (overflow) begin
      flag_reg <= 1'b1;
    end else if (wrFlag && !wdata[FLAG_OVF]) begin
      flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg & inten_reg & pctrl_reg[PCTRL_GIE];
    end
  end

  assign irqOut = irq_reg;

  // ---------------- assertions ----------------
  // helper for the ratio check: source events seen since the last count,
  // kept apart from the prescaler so the check does not restate its mask
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      evtSince_reg <= '0;
    end else if (countEvent || (wrMode && !wdata[MODE_PSA])) begin
      evtSince_reg <= '0;
    end else if (run && srcEvent && !psa) begin
      evtSince_reg <= evtSince_reg + 9'h001;
    end
  end

  sequence s_quiet;
    !wrEn;
  endsequence

  sequence s_ext_sync_rise;
    srcSel && !slowSel && !async && psa && run && !mode_reg[MODE_EDGE]
      && $rose(selLevel);
  endsequence

  sequence s_ext_async_rise;
    srcSel && !slowSel && async && psa && run && !mode_reg[MODE_EDGE]
      && $rose(selLevel);
  endsequence

  sequence s_slow_fall;
    srcSel && slowSel && cfg_reg[CFG_T0SRC] && !async && psa && run
      && mode_reg[MODE_EDGE] && $fell(selLevel);
  endsequence

  a_count_stopped: assert property (@(posedge clock)
    disable iff (!reset_n)
    !run && !wrCount |=> $stable(count_reg))
    else $error("counter moved while stopped");

  a_count_load: assert property (@(posedge clock)
    disable iff (!reset_n)
    wrCount |=> count_reg == $past(wdata))
    else $error("count write not loaded");

  a_count_read: assert property (@(posedge clock)
    disable iff (!reset_n)
    access && !rsp_reg.pready && !apbReq.pwrite
      && apbReq.paddr == OFF_COUNT
      |=> rsp_reg.pready && rsp_reg.prdata[7:0] == $past(count_reg))
    else $error("count read wrong");

  a_instr_count: assert property (@(posedge clock)
    disable iff (!reset_n)
    (run && !srcSel && psa) and s_quiet
      |=> count_reg == 8'($past(count_reg) + 8'h01))
    else $error("instruction clock not counted");

  a_sync_edge: assert property (@(posedge clock)
    disable iff (!reset_n)
    s_ext_sync_rise ##1 s_quiet ##1 s_quiet
      |-> count_reg == 8'($past(count_reg, 2) + 8'h01))
    else $error("synchronised edge not counted after two cycles");

  a_async_edge: assert property (@(posedge clock)
    disable iff (!reset_n)
    s_ext_async_rise ##1 s_quiet
      |-> count_reg == 8'($past(count_reg) + 8'h01))
    else $error("async edge not counted after one cycle");

  a_slow_edge: assert property (@(posedge clock)
    disable iff (!reset_n)
    s_slow_fall ##1 s_quiet ##1 s_quiet
      |-> count_reg == 8'($past(count_reg, 2) + 8'h01))
    else $error("slow oscillator falling edge not counted");

  a_psc_divide: assert property (@(posedge clock)
    disable iff (!reset_n)
    countEvent && !psa |-> (psc_reg & pscMask) == pscMask)
    else $error("prescaler passed an event early");

  a_psc_ratio: assert property (@(posedge clock)
    disable iff (!reset_n)
    countEvent && !psa
      |-> (evtSince_reg + 9'h001) == (9'h002 << mode_reg[2:0]))
    else $error("prescaler ratio not kept");

  a_psc_step: assert property (@(posedge clock)
    disable iff (!reset_n)
    run && srcEvent && !psa && !wrMode
      |=> psc_reg == 8'($past(psc_reg) + 8'h01))
    else $error("prescaler missed a source event");

  a_psc_frozen: assert property (@(posedge clock)
    disable iff (!reset_n)
    !run && !wrMode |=> $stable(psc_reg))
    else $error("prescaler moved while stopped");

  a_psc_clear: assert property (@(posedge clock)
    disable iff (!reset_n)
    wrMode && !wdata[MODE_PSA] |=> psc_reg == PSC_RST)
    else $error("prescaler not cleared on assignment");

  a_psc_handoff: assert property (@(posedge clock)
    disable iff (!reset_n)
    psa |=> $stable(psc_reg) || $past(wrMode))
    else $error("prescaler advanced while handed away");

  a_ovf_wrap: assert property (@(posedge clock)
    disable iff (!reset_n)
    overflow |=> count_reg == 8'h00 && flag_reg)
    else $error("overflow did not wrap and flag");

  a_flag_sticky: assert property (@(posedge clock)
    disable iff (!reset_n)
    flag_reg && !(wrFlag && !wdata[FLAG_OVF]) |=> flag_reg)
    else $error("overflow flag dropped on its own");

  a_flag_clear: assert property (@(posedge clock)
    disable iff (!reset_n)
    wrFlag && !wdata[FLAG_OVF] && !overflow |=> !flag_reg)
    else $error("overflow flag not cleared by software");

  a_irq_quiet: assert property (@(posedge clock)
    disable iff (!reset_n)
    !(flag_reg && inten_reg && pctrl_reg[PCTRL_GIE]) |=> !irq_reg)
    else $error("interrupt raised without flag and enables");

  a_irq_raise: assert property (@(posedge clock)
    disable iff (!reset_n)
    flag_reg && inten_reg && pctrl_reg[PCTRL_GIE] ##1 flag_reg
      |-> irq_reg)
    else $error("interrupt not raised");
endmodule

// >>> tb/test_tmz_timer0.sv
// Purpose: self-checking bench for the eight-bit up-counting timer
// Assumes: APB answers within a few cycles; pins held >= 3 cycles per level
// Notes: a run window starts after the run-enable write lands and ends on the landing edge of the stop write
`timescale 1ns/100ps
module test_tmz_timer0;
  import tmz_pkg::*;
  logic clock = 0;
  logic reset_n = 0;
  tmz_apb_req_s req = '0;
  tmz_apb_rsp_s rsp;
  logic pinExt = 0, pinRc = 0, pinXtal = 0;
  logic irq;
  logic lastErr;
  logic [31:0] q;
  int fails = 0, total_checks = 0, seed = 32'h6f80;
  logic [7:0] mTab [6] = '{8'h28, 8'h38, 8'ha8, 8'ha8, 8'hb8, 8'h28};
  logic [7:0] cTab [6] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h06, 8'h01};
  int sTab [6] = '{0, 0, 0, 1, 2, 0};

  tmz_timer0 tmz_timer0_i (
    .clock(clock), .reset_n(reset_n), .apbReq(req), .apbRsp(rsp),
    .extCountIn(pinExt), .intSlowRc(pinRc), .extSlowXtal(pinXtal),
    .irqOut(irq));

  always #5 clock = ~clock;

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req.psel <= 1; req.penable <= 0; req.pwrite <= wr;
    req.paddr <= a; req.pwdata <= d;
    @(posedge clock);
    req.penable <= 1;
    // read right at the edge, rsp still shows what this edge samples
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 40);
    q = rsp.prdata;
    lastErr = rsp.pslverr;
    if (n >= 40) begin
      fails++;
      print_verdict();
    end
    req.psel <= 0;
    req.penable <= 0;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, s);
      fails++;
    end
  endtask

  // counts expected from a cleared prescaler after a number of events
  function automatic int div_count(input int events, input int ratio);
    return events / (2 << ratio);
  endfunction

  task automatic pin(input int sel, input logic v);
    @(posedge clock);
    if (sel == 0) pinExt <= v;
    else if (sel == 1) pinRc <= v;
    else pinXtal <= v;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    print_verdict();
  end

  initial begin
    int n, dv, w;
    logic [7:0] v;
    repeat (2) @(posedge clock);
    reset_n <= 1;
    for (int a = 0; a <= 8'h18; a += 4) begin
      apb(0, a[7:0], 0);
      chk("reset value", 0, q);
    end
    apb(0, 8'h1c, 0);
    chk("unmapped error", 1, {31'b0, lastErr});
    chk("unmapped data", 0, q);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v = 8'($random(seed));
      apb(1, OFF_COUNT, {24'h0, v});
      apb(0, OFF_COUNT, 0);
      chk("count load", {24'h0, v}, q);
    end
    $display("test load done");
    // instruction clock through every prescaler ratio, slow select ignored
    for (int r = 0; r < 8; r++) begin
      dv = 2 << r;
      w = dv * 5;
      apb(1, OFF_PCTRL, 0);
      apb(1, OFF_MODE, 8'h80 | r);
      apb(1, OFF_COUNT, 0);
      apb(1, OFF_PCTRL, 1);
      repeat (w) @(posedge clock);
      apb(1, OFF_PCTRL, 0);
      apb(0, OFF_COUNT, 0);
      // w edges plus all four edges of the stopping run write see the source
      chk("divided count", div_count(w + 4, r), q);
    end
    $display("test prescaler done");
    for (int t = 0; t < 6; t++) begin
      n = 2 + {$random(seed)} % 6;
      apb(1, OFF_PCTRL, 0);
      apb(1, OFF_MODE, mTab[t]);
      apb(1, OFF_CFG, cTab[t]);
      apb(1, OFF_COUNT, 0);
      apb(1, OFF_PCTRL, 1);
      repeat (4) @(posedge clock);
      // levels held 3 cycles keep the source slower than the clock
      for (int i = 0; i < n; i++) begin
        pin(sTab[t], 1);
        repeat (2) @(posedge clock);
        if (i < n - 1) pin(sTab[t], 0);
        repeat (2) @(posedge clock);
      end
      repeat (8) @(posedge clock);
      apb(1, OFF_PCTRL, 0);
      apb(0, OFF_COUNT, 0);
      chk("pin count", mTab[t][4] ? n - 1 : n, q);
      pin(sTab[t], 0);
      repeat (2) @(posedge clock);
      apb(0, OFF_COUNT, 0);
      chk("frozen count", mTab[t][4] ? n - 1 : n, q);
    end
    apb(1, OFF_CFG, 0);
    $display("test sources done");
    apb(1, OFF_MODE, 8'h08);
    apb(1, OFF_COUNT, 8'hfe);
    apb(1, OFF_INTEN, 1);
    apb(1, OFF_PCTRL, 8'h81);
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk("interrupt raised", 1, irq);
    apb(1, OFF_PCTRL, 8'h80);
    apb(0, OFF_COUNT, 0);
    chk("wrapped count small", 1, q < 32'h10);
    apb(1, OFF_FLAG, 1);
    apb(0, OFF_FLAG, 0);
    chk("flag kept", 1, q);
    apb(1, OFF_INTEN, 0);
    repeat (3) @(posedge clock);
    chk("masked interrupt", 0, irq);
    apb(1, OFF_INTEN, 1);
    repeat (3) @(posedge clock);
    chk("unmasked interrupt", 1, irq);
    apb(1, OFF_PCTRL, 0);
    repeat (3) @(posedge clock);
    chk("global disable", 0, irq);
    apb(1, OFF_FLAG, 0);
    apb(0, OFF_FLAG, 0);
    chk("flag cleared", 0, q);
    $display("test overflow done");
    print_verdict();
  end
endmodule
